// >>> resolver_pkg.sv
package resolver_pkg;
  // position word
  localparam int POS_BITS = 12;
  // bench clock
  localparam int CLK_PERIOD_NS = 40;
  // step strobe width, a least time, rounded up
  localparam int STROBE_NS = 300;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // nominal top step rate, turned into a least spacing in cycles
  localparam int STEP_RATE_KHZ = 1536;
  localparam int STEP_PERIOD_NS = (1000000 + STEP_RATE_KHZ - 1) / STEP_RATE_KHZ;
  localparam int STEP_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // three-level width strap as two logic bits
  localparam logic [1:0] WSEL_180 = 2'h0;
  localparam logic [1:0] WSEL_90 = 2'h1;
  localparam logic [1:0] WSEL_360 = 2'h2;
  localparam logic [1:0] WSEL_OPEN = 2'h3;
  // index width in counter steps; one quadrature cycle is four steps
  localparam logic [2:0] IDX_STEPS_90 = 3'h1;
  localparam logic [2:0] IDX_STEPS_180 = 3'h2;
  localparam logic [2:0] IDX_STEPS_360 = 3'h4;
  // reset values
  localparam logic RST_INDEX = 1'b1;
  localparam logic RST_DIR = 1'b1;
endpackage

// >>> ser_if.sv
`timescale 1ns/1ps
interface ser_if import resolver_pkg::*; #(parameter int W = POS_BITS);
  logic capture;
  logic shift;
  logic [W-1:0] word;
  logic sdo;
  modport ctl (output capture, output shift, output word, input sdo);
  modport shf (input capture, input shift, input word, output sdo);
endinterface

// >>> pos_shifter.sv
`timescale 1ns/1ps
module pos_shifter import resolver_pkg::*; #(
  parameter int W = POS_BITS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // control from the serial port logic
  ser_if.shf sp
);
  // elaboration check: the shift path needs at least two bits
  if (W < 2) begin : g_bad_width
    $error("W out of range");
  end

  logic [W-1:0] shreg_ff;
  logic [W-1:0] nxt_shreg;
  logic sdo_ff;
  logic nxt_sdo;

  // snapshot on select fall, msb out first, zeros fill behind
  always_comb begin
    nxt_shreg = shreg_ff;
    nxt_sdo = sdo_ff;
    if (sp.capture) begin
      nxt_shreg = sp.word;
      nxt_sdo = 1'b0;
    end else if (sp.shift) begin
      nxt_sdo = shreg_ff[W-1];
      nxt_shreg = {shreg_ff[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shreg_ff <= '0;
      sdo_ff <= 1'b0;
    end else begin
      shreg_ff <= nxt_shreg;
      sdo_ff <= nxt_sdo;
    end
  end

  assign sp.sdo = sdo_ff;
endmodule

// >>> resolver_position_output.sv
`timescale 1ns/1ps
module resolver_position_output import resolver_pkg::*; #(
  parameter int POS_W = POS_BITS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // step requests from the tracking loop, same clock
  input wire logic step_up_i,
  input wire logic step_down_i,
  // serial port pins
  input wire logic select_n_i,
  input wire logic sclk_i,
  output logic data_o,
  output logic data_oe_n_o,
  // encoder emulation
  input wire logic [1:0] index_width_select_i,
  output logic quad_a_o,
  output logic quad_b_o,
  output logic dir_o,
  output logic index_pulse_o,
  output logic lsb_step_strobe_o
);
  // elaboration check: counter widths below are sized for these limits
  if (POS_W < 4 || POS_W > 24 || STEP_CYC > 32 || STROBE_CYC > 15) begin : g_bad_param
    $error("POS_W or timing counts out of range");
  end

  // two-flop synchronisers for all pin inputs
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
    end else begin
      sync1_ff <= {index_width_select_i, sclk_i, select_n_i};
      sync2_ff <= sync1_ff;
    end
  end
  logic sel_s;
  logic sclk_s;
  logic [1:0] wsel_s;
  assign sel_s = sync2_ff[0];
  assign sclk_s = sync2_ff[1];
  assign wsel_s = sync2_ff[3:2];

  // step group: counter, strobe, direction, quadrature, index
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] nxt_pos;
  logic [4:0] gap_ff;
  logic [4:0] nxt_gap;
  logic [3:0] str_cnt_ff;
  logic [3:0] nxt_str_cnt;
  logic strobe_ff;
  logic nxt_strobe;
  logic dir_ff;
  logic nxt_dir;
  logic qa_ff;
  logic nxt_qa;
  logic qb_ff;
  logic nxt_qb;
  logic index_ff;
  logic nxt_index;
  logic accept;
  logic [2:0] idx_steps;

  // steps closer than the rate limit are dropped, loop must retry
  always_comb begin
    accept = (step_up_i ^ step_down_i) && (gap_ff == 5'h0);
    nxt_pos = pos_ff;
    nxt_dir = dir_ff;
    nxt_gap = (gap_ff != 5'h0) ? gap_ff - 5'h1 : 5'h0;
    nxt_str_cnt = (str_cnt_ff != 4'h0) ? str_cnt_ff - 4'h1 : 4'h0;
    if (accept) begin
      nxt_pos = step_up_i ? pos_ff + POS_W'(1) : pos_ff - POS_W'(1);
      nxt_dir = step_up_i;
      nxt_gap = 5'(STEP_CYC - 1);
      nxt_str_cnt = 4'(STROBE_CYC);
    end
    nxt_strobe = (nxt_str_cnt != 4'h0);
    case (wsel_s)
      WSEL_180: idx_steps = IDX_STEPS_180;
      WSEL_360: idx_steps = IDX_STEPS_360;
      WSEL_90: idx_steps = IDX_STEPS_90;
      default: idx_steps = IDX_STEPS_90;
    endcase
    nxt_index = (nxt_pos < POS_W'(idx_steps));
    nxt_qa = nxt_pos[1];
    nxt_qb = nxt_pos[1] ^ nxt_pos[0];
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_ff <= '0;
      gap_ff <= 5'h0;
      str_cnt_ff <= 4'h0;
      strobe_ff <= 1'b0;
      dir_ff <= RST_DIR;
      qa_ff <= 1'b0;
      qb_ff <= 1'b0;
      index_ff <= RST_INDEX;
    end else begin
      pos_ff <= nxt_pos;
      gap_ff <= nxt_gap;
      str_cnt_ff <= nxt_str_cnt;
      strobe_ff <= nxt_strobe;
      dir_ff <= nxt_dir;
      qa_ff <= nxt_qa;
      qb_ff <= nxt_qb;
      index_ff <= nxt_index;
    end
  end

  // serial port group: edges found on synchronised pins
  logic sel_d_ff;
  logic sclk_d_ff;
  logic oe_n_ff;
  logic nxt_oe_n;
  logic sel_fall;
  logic sclk_fall;
  ser_if #(.W(POS_W)) sp ();

  // word is frozen at select fall, so the counter keeps moving freely
  always_comb begin
    sel_fall = sel_d_ff && !sel_s;
    sclk_fall = sclk_d_ff && !sclk_s;
    nxt_oe_n = sel_s;
    sp.capture = sel_fall;
    sp.shift = sclk_fall && !sel_s && !sel_fall;
    sp.word = pos_ff;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_d_ff <= 1'b1;
      sclk_d_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      sel_d_ff <= sel_s;
      sclk_d_ff <= sclk_s;
      oe_n_ff <= nxt_oe_n;
    end
  end

  pos_shifter #(.W(POS_W)) u_shifter (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .sp(sp.shf)
  );

  // outputs, all from flops
  assign data_o = sp.sdo;
  assign data_oe_n_o = oe_n_ff;
  assign quad_a_o = qa_ff;
  assign quad_b_o = qb_ff;
  assign dir_o = dir_ff;
  assign index_pulse_o = index_ff;
  assign lsb_step_strobe_o = strobe_ff;

  // helper state for checks only
  logic [4:0] bit_cnt_ff;
  logic [POS_W-1:0] snap_ff;
  logic [4:0] since_ff;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_ff <= 5'h0;
      snap_ff <= '0;
      since_ff <= 5'h1F;
    end else begin
      if (sp.capture) begin
        bit_cnt_ff <= 5'h0;
        snap_ff <= pos_ff;
      end else if (sp.shift && bit_cnt_ff != 5'h1F) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h1;
      end
      if (strobe_ff && !$past(strobe_ff)) begin
        since_ff <= 5'h0;
      end else if (since_ff != 5'h1F) begin
        since_ff <= since_ff + 5'h1;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_sel_fall;
    $fell(sel_s);
  endsequence
  sequence s_strobe_high;
    lsb_step_strobe_o [*8];
  endsequence

  a_idle_hiz: assert property (sel_s |=> data_oe_n_o)
    else $error("data driven while select high");
  a_oe_on_fall: assert property (
      s_sel_fall |=> !data_oe_n_o ##1 (data_oe_n_o == $past(sel_s)))
    else $error("driver not enabled on select fall");
  a_first_bit: assert property (
      sp.shift && bit_cnt_ff == 5'h0 |=> data_o == snap_ff[POS_W-1])
    else $error("first bit not msb of snapshot");
  a_zero_fill: assert property (sp.shift && bit_cnt_ff >= 5'(POS_W) |=> !data_o)
    else $error("no zero after full word");
  a_dir_follow: assert property (accept |=> dir_o == $past(step_up_i))
    else $error("direction wrong after step");
  a_index_zero: assert property (pos_ff == '0 |-> index_pulse_o)
    else $error("index missing at zero");
  // index follows the strap one cycle late, so compare with last cycle's strap
  a_index_width: assert property (
      pos_ff == POS_W'(3) |-> index_pulse_o == ($past(wsel_s) == WSEL_360))
    else $error("index width wrong");
  a_open_ninety: assert property (
      $past(wsel_s) == WSEL_OPEN && pos_ff == POS_W'(1) |-> !index_pulse_o)
    else $error("open strap not 90 degree");
  a_strobe_width: assert property (
      $rose(lsb_step_strobe_o) |-> s_strobe_high ##1 !lsb_step_strobe_o)
    else $error("strobe not 8 cycles");
  a_strobe_space: assert property (
      $rose(lsb_step_strobe_o) |-> since_ff >= 5'(STEP_CYC - 1))
    else $error("strobes too close");
  a_step_strobe: assert property (accept |=> $rose(lsb_step_strobe_o))
    else $error("step without strobe");
  a_one_lsb: assert property ($changed(pos_ff) |->
      (pos_ff - $past(pos_ff) == POS_W'(1)) || ($past(pos_ff) - pos_ff == POS_W'(1)))
    else $error("counter moved more than one lsb");
  // gray order 00 01 11 10 going up: b moves first, so b leads a
  a_quad_track: assert property (accept |=>
      quad_a_o == ($past(step_up_i) ? $past(quad_b_o) : !$past(quad_b_o))
      && quad_b_o == ($past(step_up_i) ? !$past(quad_a_o) : $past(quad_a_o)))
    else $error("quadrature out of step");
endmodule

// >>> host_reader.sv
`timescale 1ns/1ps
// host end of the read port; shift clock rests high between frames
module host_reader (
  // serial pins
  output logic select_n_o,
  output logic sclk_o,
  input wire logic data_i
);
  logic [15:0] word;
  event word_done;
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b1;
  end
  // one frame of n bits, sampled late in the high phase for margin
  task automatic read_word(input int n);
    #13;
    select_n_o = 1'b0;
    #600;
    word = 16'h0;
    repeat (n) begin
      sclk_o = 1'b0;
      #160;
      sclk_o = 1'b1;
      #160;
      word = {word[14:0], data_i};
    end
    #100;
    select_n_o = 1'b1;
    ->word_done;
    #600;
  endtask
endmodule

// >>> tb_resolver_position_output.sv
`timescale 1ns/1ps
module tb_resolver_position_output;
  import resolver_pkg::*;
  typedef struct packed {logic dir; logic a; logic b; logic idx;} step_t;
  logic ref_clk_i, resetn_i, step_up_i, step_down_i, select_n, sclk;
  logic [1:0] index_width_select_i;
  logic data_o, data_oe_n_o, quad_a_o, quad_b_o, dir_o, index_pulse_o, lsb_step_strobe_o;
  // an undriven pin must not show the last bit
  wire data_pin = data_oe_n_o ? ~data_o : data_o;
  int num_errors = 0, samples_checked = 0, seed = 63, hi_cnt = 0;
  logic [11:0] pos = 12'h0;
  step_t exp_steps[$];
  logic [15:0] exp_words[$];
  resolver_position_output uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .step_up_i(step_up_i), .step_down_i(step_down_i), .select_n_i(select_n),
    .sclk_i(sclk), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .index_width_select_i(index_width_select_i), .quad_a_o(quad_a_o),
    .quad_b_o(quad_b_o), .dir_o(dir_o), .index_pulse_o(index_pulse_o),
    .lsb_step_strobe_o(lsb_step_strobe_o));
  host_reader host (.select_n_o(select_n), .sclk_o(sclk), .data_i(data_pin));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic cmp_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cmp_word(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one request pulse; only an accepted one leaves a note
  task automatic step(input logic up, input logic dn, input bit acc, input int gap);
    int w;
    @(posedge ref_clk_i);
    step_up_i <= up;
    step_down_i <= dn;
    @(posedge ref_clk_i);
    step_up_i <= 1'b0;
    step_down_i <= 1'b0;
    if (acc && (up ^ dn)) begin
      pos = up ? pos + 12'h1 : pos - 12'h1;
      w = (index_width_select_i == WSEL_180) ? IDX_STEPS_180 :
          (index_width_select_i == WSEL_360) ? IDX_STEPS_360 : IDX_STEPS_90;
      exp_steps.push_back('{up, pos[1], pos[1] ^ pos[0], pos < w});
    end
    repeat (gap) @(posedge ref_clk_i);
  endtask
  task automatic read(input int n);
    exp_words.push_back(n == 12 ? {4'h0, pos} : {pos, 4'h0});
    host.read_word(n);
    cmp_bit("data enable idle", 1'b1, data_oe_n_o);
  endtask
  // strobe watcher: state at the rise, width at the fall
  always @(negedge ref_clk_i) begin
    if (lsb_step_strobe_o === 1'b1) begin
      hi_cnt++;
      if (hi_cnt == 1 && exp_steps.size() == 0) begin
        num_errors++;
        $display("FAIL strobe expected none seen 1");
      end else if (hi_cnt == 1) begin
        cmp_word("step outputs", {12'h0, exp_steps.pop_front()},
          {12'h0, dir_o, quad_a_o, quad_b_o, index_pulse_o});
      end
    end else if (hi_cnt != 0) begin
      cmp_word("strobe width", 16'(STROBE_CYC), 16'(hi_cnt));
      hi_cnt = 0;
    end
  end
  always @(host.word_done) cmp_word("serial word", exp_words.pop_front(), host.word);
  always @(posedge sclk) if (select_n === 1'b0) cmp_bit("data enable", 1'b0, data_oe_n_o);
  initial begin
    int r;
    resetn_i = 1'b0;
    step_up_i = 1'b0;
    step_down_i = 1'b0;
    index_width_select_i = WSEL_OPEN;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    for (int c = 0; c < 4; c++) begin
      index_width_select_i <= 2'(c);
      repeat (4) @(posedge ref_clk_i);
      // walk down through zero, then back up through it
      while (pos != 12'hFFA) step(1'b0, 1'b1, 1'b1, 18);
      for (int i = 0; i < 12; i++) step(1'b1, 1'b0, 1'b1, 18);
      for (int i = 0; i < 8; i++) begin
        r = $random(seed);
        step(r[0], ~r[0], 1'b1, 18);
      end
      step(1'b1, 1'b0, 1'b1, 3);
      step(1'b0, 1'b1, 1'b0, 18); // too soon after the last, dropped
      step(1'b1, 1'b1, 1'b1, 18); // both high, no step
      read(c == 3 ? 16 : 12);
      $display("test %0d done", c);
    end
    cmp_word("pending steps", 16'h0, 16'(exp_steps.size()));
    print_verdict();
  end
  // hang guard, about three times the expected run
  initial begin
    #400000;
    num_errors++;
    $display("FAIL watchdog expected done seen hang");
    print_verdict();
  end
endmodule
